/* File: ir_timer_common_control.sv */
// The plain strobed port was left to the implementer.
`include "ir_timer_regs.svh"
`default_nettype none
module ir_timer_common_control (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // timer side
  input  wire logic       narrow_timer_output_i,
  input  wire logic       wide_timer_output_i,
  input  wire logic       pingpong_sel_i,
  input  wire logic       timer_load_i,
  output logic            wide_timer_output_o,
  output logic            narrow_timer_output_o,
  output logic            demod_edge_o,
  // pins
  input  wire logic       port3_bit6_data_i,
  input  wire logic       port3_bit1_pin_i,
  input  wire logic       port2_bit0_pin_i,
  output logic            port3_bit6_pin_o,
  output logic            demod_level_o,
  // interrupt
  output logic            irq_o
);
  // state held in flip-flops, one per concern
  logic [7:0] timer8_control_ff;         // narrow timer control store
  logic [7:0] timers_common_control_ff;  // shared control
  logic [7:0] timer16_control_ff;        // wide timer control store
  logic       fall_flag_ff;              // demod falling edge seen
  logic       rise_flag_ff;              // demod rising edge seen
  logic [1:0] irq_status_ff;             // sticky events
  logic [1:0] irq_mask_ff;               // event enables
  logic [7:0] rdata_ff;                  // read data, one cycle late
  logic       wide_out_ff;               // shaped wide output
  logic       narrow_out_ff;             // shaped narrow output
  logic       pin36_ff;                  // port3 bit6 drive
  logic       level_ff;                  // previous filtered level
  logic       edge_ff;                   // selected edge pulse
  logic       irq_ff;                    // interrupt level
  // combinational nets; none of them reaches a port directly
  logic       raw_in;                    // selected demod input
  logic       filt_in;                   // filtered demod input
  logic       combined_timer_output;     // gated pair of outputs
  logic       nxt_wide;                  // wide output after mode
  logic       nxt_narrow;                // narrow output after start level
  logic       rise_ev;                   // filtered rising edge
  logic       fall_ev;                   // filtered falling edge
  logic       demod;                     // demodulation mode active
  logic [7:0] nxt_rdata;                 // read mux

  // every access goes through this one compare, so the write
  // decode and the read mux can never disagree on an offset
  // only the low offsets are mapped; anything else is ignored
  // single decode shared by write and read
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // mode bit: 0 transmit, 1 demodulation; every other field of the
  // common control register changes meaning with it
  // transmit mode is the reset state
  assign demod = timers_common_control_ff[`TMR_BIT_DEMOD];

  // demod input pin select
  // bit 6 picks port2 bit0 when set, else port3 bit1; the pin left
  // out is ignored, so a noisy idle line there cannot cause edges
  assign raw_in = timers_common_control_ff[`TMR_BIT_PINSEL] ? port2_bit0_pin_i
                                                          : port3_bit1_pin_i;

  // glitch filter on the selected input; in transmit mode it is
  // forced to pass-through, so leaving demodulation never strands
  // a half-counted candidate level
  // the filter length comes straight from the out mode field
  ir_glitch_filter u_filter (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .sel_i   (demod ? timers_common_control_ff[`TMR_FLD_OUTMODE_LO +: 2] : 2'b00),
    .raw_i   (raw_in),
    .clean_o (filt_in)
  );

  // edges of the filtered level against its copy from one cycle ago
  // level_ff resets low like the idle receiver line, so no false
  // rising edge follows reset
  // both helpers are single-cycle pulses
  assign rise_ev = filt_in & ~level_ff;
  assign fall_ev = ~filt_in & level_ff;

  // transmit start levels shown while the timers load; otherwise follow the timers
  // the out mode field then overrides the wide output:
  //   normal keeps the start level or timer output as it is,
  //   ping-pong hands it to the narrow timer while selected,
  //   the two forced codes pin it low or high
  // the narrow output has no mode of its own
  // limitation: start levels show only while timer_load_i is high
  always_comb begin
    nxt_narrow = timer_load_i ? timers_common_control_ff[`TMR_BIT_NARROW_START]
                              : narrow_timer_output_i;
    nxt_wide   = timer_load_i ? timers_common_control_ff[`TMR_BIT_WIDE_START]
                              : wide_timer_output_i;
    case (ir_timer_pkg::out_mode_t'(timers_common_control_ff[`TMR_FLD_OUTMODE_LO +: 2]))
      ir_timer_pkg::OUT_PINGPONG: nxt_wide = pingpong_sel_i ? narrow_timer_output_i : nxt_wide;
      ir_timer_pkg::OUT_LOW:      nxt_wide = 1'b0;
      ir_timer_pkg::OUT_HIGH:     nxt_wide = 1'b1;
      default:                    nxt_wide = nxt_wide;
    endcase
  end

  // gate of the two outputs
  // built from the registered outputs, so the pin shows exactly
  // the levels that the two timer output ports show
  // the gate select is read in demodulation mode too, but the pin
  // then carries port data, so the result goes nowhere
  always_comb begin
    case (ir_timer_pkg::gate_t'(timers_common_control_ff[`TMR_FLD_LOGIC_LO +: 2]))
      ir_timer_pkg::GATE_AND:  combined_timer_output = narrow_out_ff & wide_out_ff;
      ir_timer_pkg::GATE_OR:   combined_timer_output = narrow_out_ff | wide_out_ff;
      ir_timer_pkg::GATE_NOR:  combined_timer_output = ~(narrow_out_ff | wide_out_ff);
      default:                 combined_timer_output = ~(narrow_out_ff & wide_out_ff);
    endcase
  end

  // control registers; mode change while running is software's concern
  // the narrow and wide control registers are plain storage here;
  // their fields drive no port and are only read back
  // a mode change is not blocked while the timers run: software
  // must stop them first, and the hardware does not check
  // the mask keeps only its two defined bits
  // writes land at the edge that samples wr_i and are seen by
  // every decode from the following cycle on
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      timer8_control_ff        <= `TMR_RST_CONTROL;
      timers_common_control_ff <= `TMR_RST_CONTROL;
      timer16_control_ff       <= `TMR_RST_CONTROL;
      irq_mask_ff              <= 2'b00;
    end else if (wr_i) begin
      if (hit(addr_i, `TMR_OFF_TIMER8_CONTROL)) begin
        timer8_control_ff <= wdata_i;
      end else if (hit(addr_i, `TMR_OFF_COMMON_CONTROL)) begin
        timers_common_control_ff <= wdata_i;
      end else if (hit(addr_i, `TMR_OFF_TIMER16_CONTROL)) begin
        timer16_control_ff <= wdata_i;
      end else if (hit(addr_i, `TMR_OFF_IRQ_MASK)) begin
        irq_mask_ff <= wdata_i[1:0];
      end
    end
  end

  // edge flags: detection wins over a write-one clear
  // the flags share bits 0 and 1 with the start levels and exist
  // only in demodulation mode; in transmit mode they are held clear,
  // so a stale flag never survives a trip through transmit mode
  // writing one clears a flag, writing zero leaves it alone
  // both kinds are recorded whatever the edge select says
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fall_flag_ff <= 1'b0;
      rise_flag_ff <= 1'b0;
    end else if (!demod) begin
      fall_flag_ff <= 1'b0;
      rise_flag_ff <= 1'b0;
    end else begin
      if (fall_ev) begin
        fall_flag_ff <= 1'b1;
      end else if (wr_i && hit(addr_i, `TMR_OFF_COMMON_CONTROL) && wdata_i[`TMR_BIT_WIDE_START]) begin
        fall_flag_ff <= 1'b0;
      end
      if (rise_ev) begin
        rise_flag_ff <= 1'b1;
      end else if (wr_i && hit(addr_i, `TMR_OFF_COMMON_CONTROL) && wdata_i[`TMR_BIT_NARROW_START]) begin
        rise_flag_ff <= 1'b0;
      end
    end
  end

  // sticky interrupt status: bit0 falling, bit1 rising; write one clears
  // set wins over a clear in the same cycle, so an event is never
  // lost to a badly timed acknowledge
  // events are counted in demodulation mode only
  // the loop covers both bits; bit0 takes falling and bit1 rising
  // a mode or filter change raises no event of its own
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_status_ff <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (demod && (i == 0 ? fall_ev : rise_ev)) begin
          irq_status_ff[i] <= 1'b1;
        end else if (wr_i && hit(addr_i, `TMR_OFF_IRQ_STATUS) && wdata_i[i]) begin
          irq_status_ff[i] <= 1'b0;
        end
      end
    end
  end

  // demod edge tracking and selected edge output
  // level_ff is also the demod_level_o port, one cycle behind the filter
  // the pulse lasts one cycle and comes with the level update
  // the reserved select code falls back to falling edges rather
  // than leaving the pulse undefined
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      level_ff <= 1'b0;
      edge_ff  <= 1'b0;
    end else begin
      level_ff <= filt_in;
      // reserved code treated as falling
      edge_ff  <= demod && (timers_common_control_ff[`TMR_FLD_LOGIC_LO +: 2] == 2'b01 ? rise_ev
                                                                                   : fall_ev);
    end
  end

  // transmit output shaping and pin drive
  // all three pin-side outputs are registered, so nothing glitches
  // while the gate select or the mode bit is being rewritten
  // in demodulation mode both timer outputs are parked low
  // trade-off: one cycle of extra lag on the combined output
  // port data pass through a register too, for equal timing
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wide_out_ff   <= 1'b0;
      narrow_out_ff <= 1'b0;
      pin36_ff      <= 1'b0;
    end else begin
      wide_out_ff   <= demod ? 1'b0 : nxt_wide;
      narrow_out_ff <= demod ? 1'b0 : nxt_narrow;
      // in demod mode the pin stays a plain port output
      pin36_ff      <= (!demod && timers_common_control_ff[`TMR_BIT_PINSEL]) ? combined_timer_output
                                                                         : port3_bit6_data_i;
    end
  end

  // read mux; flags replace start bits in demod mode
  // the stored start bits stay intact under the flags and show
  // again after a return to transmit mode
  // unmapped offsets read as zero
  // the status and mask registers fill only their low two bits
  // reads have no side effects: no flag is cleared by a read
  always_comb begin
    nxt_rdata = 8'h00;
    if (hit(addr_i, `TMR_OFF_TIMER8_CONTROL)) begin
      nxt_rdata = timer8_control_ff;
    end else if (hit(addr_i, `TMR_OFF_COMMON_CONTROL)) begin
      nxt_rdata = timers_common_control_ff;
      if (demod) begin
        nxt_rdata[`TMR_BIT_WIDE_START]   = fall_flag_ff;
        nxt_rdata[`TMR_BIT_NARROW_START] = rise_flag_ff;
      end
    end else if (hit(addr_i, `TMR_OFF_TIMER16_CONTROL)) begin
      nxt_rdata = timer16_control_ff;
    end else if (hit(addr_i, `TMR_OFF_IRQ_STATUS)) begin
      nxt_rdata = {6'h00, irq_status_ff};
    end else if (hit(addr_i, `TMR_OFF_IRQ_MASK)) begin
      nxt_rdata = {6'h00, irq_mask_ff};
    end
  end

  // read data register and interrupt level
  // read data stand for the one cycle after the strobe and are zero
  // otherwise, which keeps a shared read bus quiet
  // the interrupt is a level one cycle behind the status bits
  // and drops once software clears the status or masks it
  // the mask does not gate the status bits themselves, so software
  // can poll events it has chosen not to be interrupted by
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
      irq_ff   <= 1'b0;
    end else begin
      rdata_ff <= rd_i ? nxt_rdata : 8'h00;
      irq_ff   <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // every output comes straight from a flip-flop
  // no logic sits between these registers and the ports
  // the filter output itself stays inside; only level_ff leaves
  assign rdata_o               = rdata_ff;
  assign wide_timer_output_o   = wide_out_ff;
  assign narrow_timer_output_o = narrow_out_ff;
  assign port3_bit6_pin_o      = pin36_ff;
  assign demod_level_o         = level_ff;
  assign demod_edge_o          = edge_ff;
  assign irq_o                 = irq_ff;
endmodule : ir_timer_common_control
`default_nettype wire

/* File: ir_timer_regs.svh */
`ifndef IR_TIMER_REGS_SVH
`define IR_TIMER_REGS_SVH
// register offsets
`define TMR_OFF_TIMER8_CONTROL   8'h00
`define TMR_OFF_COMMON_CONTROL   8'h01
`define TMR_OFF_TIMER16_CONTROL  8'h02
`define TMR_OFF_IRQ_STATUS       8'h03
`define TMR_OFF_IRQ_MASK         8'h04
// common control field positions
`define TMR_BIT_WIDE_START       0
`define TMR_BIT_NARROW_START     1
`define TMR_FLD_OUTMODE_LO       2
`define TMR_FLD_LOGIC_LO         4
`define TMR_BIT_PINSEL           6
`define TMR_BIT_DEMOD            7
// reset values
`define TMR_RST_CONTROL          8'h00
// filter lengths in system clock cycles
`define TMR_FILT_SHORT           5'h04
`define TMR_FILT_MID             5'h08
`define TMR_FILT_LONG            5'h10
`endif

/* File: ir_timer_pkg.sv */
`default_nettype none
package ir_timer_pkg;
  // transmit output behaviour of the wide timer
  typedef enum logic [1:0] {
    OUT_NORMAL   = 2'b00,
    OUT_PINGPONG = 2'b01,
    OUT_LOW      = 2'b10,
    OUT_HIGH     = 2'b11
  } out_mode_t;
  // gate combining both timer outputs
  typedef enum logic [1:0] {
    GATE_AND  = 2'b00,
    GATE_OR   = 2'b01,
    GATE_NOR  = 2'b10,
    GATE_NAND = 2'b11
  } gate_t;
  // glitch filter tracking state
  typedef enum logic [0:0] {
    FILT_IDLE  = 1'b0,
    FILT_TRACK = 1'b1
  } filt_state_t;
endpackage : ir_timer_pkg
`default_nettype wire

/* File: ir_glitch_filter.sv */
`include "ir_timer_regs.svh"
`default_nettype none
module ir_glitch_filter (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic [1:0] sel_i,
  // signal
  input  wire logic       raw_i,
  output logic            clean_o
);
  logic [4:0]                   cnt_ff;   // cycles the new level has held
  logic                         clean_ff; // accepted level
  ir_timer_pkg::filt_state_t    st_ff;    // tracking a candidate change
  logic [4:0]                   need;     // required stable cycles

  // filter length from the selection code
  always_comb begin
    case (sel_i)
      2'b01:   need = `TMR_FILT_SHORT;
      2'b10:   need = `TMR_FILT_MID;
      2'b11:   need = `TMR_FILT_LONG;
      default: need = 5'h00;
    endcase
  end

  // accept a change only after it held long enough
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_ff   <= 5'h00;
      clean_ff <= 1'b0;
      st_ff    <= ir_timer_pkg::FILT_IDLE;
    end else if (sel_i == 2'b00) begin
      // no filter: follow input directly
      clean_ff <= raw_i;
      cnt_ff   <= 5'h00;
      st_ff    <= ir_timer_pkg::FILT_IDLE;
    end else begin
      case (st_ff)
        ir_timer_pkg::FILT_IDLE: begin
          if (raw_i != clean_ff) begin
            cnt_ff <= 5'h01;
            st_ff  <= ir_timer_pkg::FILT_TRACK;
          end
        end
        default: begin
          if (raw_i == clean_ff) begin
            // glitch: candidate dropped
            st_ff <= ir_timer_pkg::FILT_IDLE;
          end else if (cnt_ff >= need) begin
            clean_ff <= raw_i;
            st_ff    <= ir_timer_pkg::FILT_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 5'h01;
          end
        end
      endcase
    end
  end

  assign clean_o = clean_ff;
endmodule : ir_glitch_filter
`default_nettype wire

/* File: ir_timer_common_control_properties.sv */
`include "ir_timer_regs.svh"
`default_nettype none
module ir_timer_common_control_properties (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // timers and pins
  input wire logic       timer_load_i,
  input wire logic       wide_timer_output_o,
  input wire logic       narrow_timer_output_o,
  input wire logic       demod_edge_o,
  input wire logic       port3_bit6_data_i,
  input wire logic       port3_bit1_pin_i,
  input wire logic       port2_bit0_pin_i,
  input wire logic       port3_bit6_pin_o,
  input wire logic       demod_level_o,
  input wire logic       irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl_ff;   // shadow of common control
  logic [7:0] mask_ff;  // shadow of irq mask
  logic [3:0] calm_ff;  // cycles since write or load, saturating
  wire logic  tx_w  = !ctl_ff[7];
  wire logic  pin_w = ctl_ff[6] ? port2_bit0_pin_i : port3_bit1_pin_i;
  // quiet time guard: outputs lag writes and loads by a cycle or two
  always_ff @(posedge mclk_i) begin
    if (rst_i || wr_i || timer_load_i) begin
      calm_ff <= 4'h0;
    end else if (calm_ff != 4'hF) begin
      calm_ff <= calm_ff + 4'h1;
    end
  end
  // shadows follow writes so the checker knows the mode
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctl_ff  <= 8'h00;
      mask_ff <= 8'h00;
    end else if (wr_i && addr_i == `TMR_OFF_COMMON_CONTROL) begin
      ctl_ff <= wdata_i;
    end else if (wr_i && addr_i == `TMR_OFF_IRQ_MASK) begin
      mask_ff <= wdata_i;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  chk_force_low: assert property (calm_ff > 4'h2 && tx_w && ctl_ff[3:2] == 2'b10 |-> !wide_timer_output_o)
    else $error("forced low output not low");
  chk_force_high: assert property (calm_ff > 4'h2 && tx_w && ctl_ff[3:2] == 2'b11 |-> wide_timer_output_o)
    else $error("forced high output not high");
  chk_demod_quiet: assert property (calm_ff > 4'h2 && !tx_w |-> !wide_timer_output_o && !narrow_timer_output_o)
    else $error("timer outputs driven in demod");
  chk_pin_port: assert property (calm_ff > 4'h2 && !(tx_w && ctl_ff[6]) && $stable(port3_bit6_data_i)
    && port3_bit6_data_i == $past(port3_bit6_data_i, 2) |-> port3_bit6_pin_o == port3_bit6_data_i)
    else $error("pin does not carry port data");
  chk_edge_single: assert property (demod_edge_o |=> !demod_edge_o)
    else $error("edge pulse longer than one cycle");
  chk_fall_edge: assert property (calm_ff > 4'h3 && !tx_w && ctl_ff[5:4] == 2'b00 && $fell(demod_level_o)
    |-> ##[0:1] demod_edge_o) else $error("falling edge not reported");
  chk_rise_edge: assert property (calm_ff > 4'h3 && !tx_w && ctl_ff[5:4] == 2'b01 && $rose(demod_level_o)
    |-> ##[0:1] demod_edge_o) else $error("rising edge not reported");
  chk_irq_masked: assert property (calm_ff > 4'h2 && mask_ff == 8'h00 |-> !irq_o)
    else $error("interrupt with all sources masked");
  chk_nofilt_follow: assert property (calm_ff > 4'h3 && !tx_w && ctl_ff[3:2] == 2'b00 && $rose(pin_w)
    |-> ##[1:3] demod_level_o) else $error("unfiltered level did not follow");
  cov_edge: cover property (demod_edge_o);
  cov_irq: cover property (irq_o);
  cov_combined: cover property (tx_w && ctl_ff[6] && port3_bit6_pin_o);
endmodule : ir_timer_common_control_properties
bind ir_timer_common_control ir_timer_common_control_properties ir_timer_common_control_properties_i (
  .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .timer_load_i(timer_load_i), .wide_timer_output_o(wide_timer_output_o),
  .narrow_timer_output_o(narrow_timer_output_o), .demod_edge_o(demod_edge_o),
  .port3_bit6_data_i(port3_bit6_data_i), .port3_bit1_pin_i(port3_bit1_pin_i),
  .port2_bit0_pin_i(port2_bit0_pin_i), .port3_bit6_pin_o(port3_bit6_pin_o),
  .demod_level_o(demod_level_o), .irq_o(irq_o));
`default_nettype wire

/* File: ir_line_model.sv */
`default_nettype none
module ir_line_model (
  // clock
  input  wire logic mclk_i,
  // commanded receiver level and routing
  input  wire logic lvl_i,
  input  wire logic alt_i,
  // receiver pins
  output logic      port3_bit1_pin_o,
  output logic      port2_bit0_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic noise_ff = 1'b0;  // idle pin pattern, flips every cycle
  // a wrongly chosen input then shows up as a burst of edges
  always_ff @(posedge mclk_i) noise_ff <= !noise_ff;
  assign port3_bit1_pin_o = alt_i ? noise_ff : lvl_i;
  assign port2_bit0_pin_o = alt_i ? lvl_i : noise_ff;
endmodule : ir_line_model
`default_nettype wire

/* File: ir_timer_common_control_tb.sv */
`include "ir_timer_regs.svh"
`default_nettype none
module ir_timer_common_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, lvl = 1'b0, alt = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic       narrow_timer_output_i = 1'b0, wide_timer_output_i = 1'b0, pingpong_sel_i = 1'b0;
  logic       timer_load_i = 1'b0, port3_bit6_data_i = 1'b0, port3_bit1_pin_i, port2_bit0_pin_i;
  logic       wide_timer_output_o, narrow_timer_output_o, demod_edge_o, port3_bit6_pin_o, demod_level_o, irq_o;
  int         err_count = 0, n_checks = 0, edges = 0;
  ir_timer_common_control ir_timer_common_control_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .narrow_timer_output_i(narrow_timer_output_i),
    .wide_timer_output_i(wide_timer_output_i), .pingpong_sel_i(pingpong_sel_i), .timer_load_i(timer_load_i),
    .wide_timer_output_o(wide_timer_output_o), .narrow_timer_output_o(narrow_timer_output_o),
    .demod_edge_o(demod_edge_o), .port3_bit6_data_i(port3_bit6_data_i), .port3_bit1_pin_i(port3_bit1_pin_i),
    .port2_bit0_pin_i(port2_bit0_pin_i), .port3_bit6_pin_o(port3_bit6_pin_o), .demod_level_o(demod_level_o),
    .irq_o(irq_o));
  ir_line_model ir_line_model_i (.mclk_i(mclk_i), .lvl_i(lvl), .alt_i(alt),
    .port3_bit1_pin_o(port3_bit1_pin_i), .port2_bit0_pin_o(port2_bit0_pin_i));
  always #4 mclk_i = ~mclk_i;
  // count reported edges
  always @(posedge mclk_i) if (demod_edge_o === 1'b1) edges <= edges + 1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // waits n edges, then settles to the falling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask : rdc
  // receiver level high for w+1 cycles, then a long quiet gap
  task automatic pulse(input int w);
    @(posedge mclk_i) lvl <= 1'b1;
    cyc(w);
    @(posedge mclk_i) lvl <= 1'b0;
    cyc(40);
  endtask : pulse
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    cyc(60000);
    err_count++;
    wrap_up();
  end
  initial begin
    int n, e0;
    logic [7:0] c;
    cyc(20);
    @(posedge mclk_i) rst_i <= 1'b0;
    wr(8'h05, 8'hFF);
    for (int a = 0; a < 6; a++) rdc(8'(a), 8'h00);
    wr(`TMR_OFF_TIMER8_CONTROL, 8'hA5);
    rdc(`TMR_OFF_TIMER8_CONTROL, 8'hA5);
    $display("test regs done");
    // start levels appear while the timers reload
    @(posedge mclk_i) timer_load_i <= 1'b1;
    for (int v = 0; v < 4; v++) begin
      wr(`TMR_OFF_COMMON_CONTROL, 8'(v));
      cyc(3);
      chk({wide_timer_output_o, narrow_timer_output_o}, {v[0], v[1]});
      rdc(`TMR_OFF_COMMON_CONTROL, 8'(v));
    end
    @(posedge mclk_i) timer_load_i <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk_i) wide_timer_output_i <= (m != 3);
      wr(`TMR_OFF_COMMON_CONTROL, 8'(m << 2));
      cyc(4);
      chk(wide_timer_output_o, 8'(m != 2));
    end
    // ping-pong: the wide output follows the narrow timer while selected
    wr(`TMR_OFF_COMMON_CONTROL, 8'h04);
    for (int s = 0; s < 2; s++) begin
      @(posedge mclk_i) {pingpong_sel_i, wide_timer_output_i} <= {s[0], 1'b1};
      cyc(4);
      chk(wide_timer_output_o, 8'(s == 0));
    end
    @(posedge mclk_i) pingpong_sel_i <= 1'b0;
    // every gate against every input pair on the shared pin
    for (int g = 0; g < 4; g++) begin
      wr(`TMR_OFF_COMMON_CONTROL, 8'(8'h40 | (g << 4)));
      for (int x = 0; x < 4; x++) begin
        @(posedge mclk_i) {wide_timer_output_i, narrow_timer_output_i} <= 2'(x);
        cyc(4);
        n = (g == 0) ? (x == 3) : (g == 1) ? (x != 0) : (g == 2) ? (x == 0) : (x != 3);
        chk(port3_bit6_pin_o, 8'(n));
      end
    end
    wr(`TMR_OFF_COMMON_CONTROL, 8'h00);
    for (int p = 1; p >= 0; p--) begin
      @(posedge mclk_i) port3_bit6_data_i <= p[0];
      cyc(4);
      chk(port3_bit6_pin_o, 8'(p));
    end
    $display("test transmit done");
    @(posedge mclk_i) {wide_timer_output_i, narrow_timer_output_i} <= 2'b00;
    wr(`TMR_OFF_COMMON_CONTROL, 8'h83);
    cyc(24);
    wr(`TMR_OFF_IRQ_STATUS, 8'h03);
    pulse(4);
    chk(irq_o, 8'h00);
    rdc(`TMR_OFF_IRQ_STATUS, 8'h03);
    wr(`TMR_OFF_IRQ_MASK, 8'h03);
    cyc(3);
    chk(irq_o, 8'h01);
    // input pin, edge and filter: every combination
    for (int k = 0; k < 16; k++) begin
      c = {1'b1, k[3], 1'b0, k[2], k[1:0], 2'b11};
      n = (k[1:0] == 0) ? 0 : 2 << k[1:0];
      @(posedge mclk_i) alt <= k[3];
      wr(`TMR_OFF_COMMON_CONTROL, c);
      cyc(24);
      wr(`TMR_OFF_COMMON_CONTROL, c);
      wr(`TMR_OFF_IRQ_STATUS, 8'h03);
      cyc(2);
      e0 = edges;
      if (n > 0) pulse(n - 2);
      rdc(`TMR_OFF_COMMON_CONTROL, c & 8'hFC);
      chk(8'(edges - e0), 8'h00);
      pulse(n + 4);
      chk(8'(edges - e0), 8'h01);
      rdc(`TMR_OFF_COMMON_CONTROL, c);
      chk(irq_o, 8'h01);
      wr(`TMR_OFF_COMMON_CONTROL, c & 8'hFC);
      rdc(`TMR_OFF_COMMON_CONTROL, c);
      wr(`TMR_OFF_COMMON_CONTROL, c);
      rdc(`TMR_OFF_COMMON_CONTROL, c & 8'hFC);
    end
    $display("test demod done");
    wrap_up();
  end
endmodule : ir_timer_common_control_tb
`default_nettype wire
